// ===== core/tmc_timer_match.sv
// Free running timer with next-match buffer, compare and match interrupt.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module tmc_timer_match (
	// Clock and reset.
	input  wire logic          core_clk,
	input  wire logic          nrst,
	// Register port.
	input  wire tmc_pkg::tmc_req_t bus_req,
	output logic [31:0]        rdata_r,
	// Interrupt.
	output logic               irq_r
);

	logic [31:0] next_match_r;
	logic [31:0] buffer_r;
	logic [31:0] count_r;
	logic [6:0]  div_r;
	logic [6:0]  tick_cnt_r;
	logic        start_r;
	logic        enable_r;
	logic [1:0]  enable_low_r;
	logic        raw_r;
	logic        tick;
	logic        hit;

	// Decode one register offset against a write strobe.
	function automatic logic wr_at(input tmc_pkg::tmc_req_t q,
		input logic [7:0] ofs);
		return q.wr && (q.addr == ofs);
	endfunction : wr_at

	// Control: start bit and clock divider.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			start_r <= tmc_pkg::RST_START;
			div_r   <= tmc_pkg::RST_DIV;
		end else if (wr_at(bus_req, tmc_pkg::OFS_CONTROL)) begin
			start_r <= bus_req.wdata[tmc_pkg::START_BIT];
			div_r   <= bus_req.wdata[tmc_pkg::DIV_LSB +: tmc_pkg::DIV_W];
		end
	end

	// Next-match value, plain read/write storage.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			next_match_r <= tmc_pkg::RST_WORD;
		end else if (wr_at(bus_req, tmc_pkg::OFS_NEXT)) begin
			next_match_r <= bus_req.wdata;
		end
	end

	// Buffer loads only from next-match, on a start write of one.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			buffer_r <= tmc_pkg::RST_WORD;
		end else if (wr_at(bus_req, tmc_pkg::OFS_CONTROL) &&
			bus_req.wdata[tmc_pkg::START_BIT]) begin
			buffer_r <= next_match_r;
		end
	end

	// Divider prescales the count by div plus one.
	assign tick = start_r && (tick_cnt_r >= div_r);

	always_ff @(posedge core_clk) begin
		if (!nrst || !start_r) begin
			tick_cnt_r <= 7'h00;
		end else if (tick) begin
			tick_cnt_r <= 7'h00;
		end else begin
			tick_cnt_r <= tick_cnt_r + 7'h01;
		end
	end

	// Counter; stopping clears it but no register contents.
	always_ff @(posedge core_clk) begin
		if (!nrst || !start_r) begin
			count_r <= tmc_pkg::RST_WORD;
		end else if (tick) begin
			count_r <= count_r + 32'h0000_0001;
		end
	end

	// Compare only while running, so a stopped zero count never matches.
	assign hit = start_r && (buffer_r == count_r);

	// Interrupt enable, with the two low bits kept as plain storage.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			enable_r     <= 1'h0;
			enable_low_r <= tmc_pkg::RST_ENABLE_LOW;
		end else if (wr_at(bus_req, tmc_pkg::OFS_ENABLE)) begin
			enable_r     <= bus_req.wdata[tmc_pkg::MATCH_BIT];
			enable_low_r <= bus_req.wdata[1:0];
		end
	end

	// Sticky raw status; a match in the clearing cycle wins.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			raw_r <= 1'h0;
		end else if (hit) begin
			raw_r <= 1'h1;
		end else if (wr_at(bus_req, tmc_pkg::OFS_CLEAR) &&
			bus_req.wdata[tmc_pkg::MATCH_BIT]) begin
			raw_r <= 1'h0;
		end
	end

	// Interrupt line registered from the current status and enable values.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			irq_r <= 1'h0;
		end else begin
			irq_r <= raw_r && enable_r;
		end
	end

	// Read data valid the cycle after the read strobe; else zero.
	always_ff @(posedge core_clk) begin
		if (!nrst || !bus_req.rd) begin
			rdata_r <= tmc_pkg::RST_WORD;
		end else begin
			unique case (bus_req.addr)
				tmc_pkg::OFS_CONTROL: rdata_r <= {9'h000, div_r, 15'h0000,
					start_r};
				tmc_pkg::OFS_ENABLE:  rdata_r <= {29'h0000_0000, enable_r,
					enable_low_r};
				tmc_pkg::OFS_RAW:     rdata_r <= {29'h0000_0000, raw_r, 2'h0};
				tmc_pkg::OFS_NEXT:    rdata_r <= next_match_r;
				tmc_pkg::OFS_BUFFER:  rdata_r <= buffer_r;
				tmc_pkg::OFS_COUNT:   rdata_r <= count_r;
				default:              rdata_r <= tmc_pkg::RST_WORD;
			endcase
		end
	end

endmodule : tmc_timer_match

// ===== core/tmc_pkg.sv
// Package with register map, field layout and reset values of the match timer.
package tmc_pkg;

	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;

	// Register offsets (byte addresses).
	localparam logic [7:0]  OFS_CONTROL    = 8'h0c;
	localparam logic [7:0]  OFS_ENABLE     = 8'h14;
	localparam logic [7:0]  OFS_RAW        = 8'h18;
	localparam logic [7:0]  OFS_CLEAR      = 8'h20;
	localparam logic [7:0]  OFS_NEXT       = 8'h24;
	localparam logic [7:0]  OFS_BUFFER     = 8'h28;
	localparam logic [7:0]  OFS_COUNT      = 8'h2c;

	// Field positions.
	localparam int          START_BIT      = 0;
	localparam int          MATCH_BIT      = 2;
	localparam int          DIV_LSB        = 16;
	localparam int          DIV_W          = 7;

	// Reset values.
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;
	localparam logic [6:0]  RST_DIV        = 7'h01;
	localparam logic        RST_START      = 1'h0;
	localparam logic [1:0]  RST_ENABLE_LOW = 2'h1;

	// Register bus request carried as one struct.
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tmc_req_t;

endpackage : tmc_pkg

// ===== dv/tmc_chk.sv
// Checker for the match timer register port and interrupt.
`timescale 1ns/1ps
module tmc_chk (
	// Watched ports.
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire tmc_pkg::tmc_req_t bus_req,
	input wire logic [31:0]       rdata_r,
	input wire logic              irq_r
);
	// Short aliases keep each property to one or two lines.
	wire        w = bus_req.wr;
	wire        r = bus_req.rd;
	wire [7:0]  a = bus_req.addr;
	wire [31:0] d = bus_req.wdata;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_clr_rd: assert property (
		r && a==8'h20 |=> rdata_r==0) else $error("clr read");
	a_clr_keep: assert property (
		w && a==8'h20 && !d[2] && irq_r |-> ##2 irq_r) else $error("kept");
	a_clr_drop: assert property (
		w && a==8'h20 && d[2] |-> ##2 !irq_r) else $error("clr irq");
	a_en_off: assert property (
		w && a==8'h14 && !d[2] |-> ##2 !irq_r) else $error("mask");
	a_next_rw: assert property (
		w && a==8'h24 ##1 r && a==8'h24 |=> rdata_r==$past(d, 2))
		else $error("next");
	a_buf_load: assert property (
		w && a==8'h24 ##1 w && a==8'h0c && d[0] ##1 r && a==8'h28
		|=> rdata_r==$past(d, 3)) else $error("buf");
	a_cnt_ro: assert property (
		w && a==8'h0c && !d[0] ##1 w && a==8'h2c ##1 r && a==8'h2c
		|=> rdata_r==0) else $error("cnt");
	a_raw_irq: assert property (
		r && a==8'h18 && irq_r && !$past(w) |=> rdata_r[2]) else $error("raw");
	cover property (irq_r ##1 !irq_r);
	cover property (w && a==8'h0c && d[0]);
	cover property (r && a==8'h18 && irq_r);
endmodule : tmc_chk
bind tmc_timer_match tmc_chk i_chk (.core_clk, .nrst, .bus_req, .rdata_r, .irq_r);

// ===== dv/tb_top.sv
// Bench for the match timer.
`timescale 1ns/1ps
module tb_top;
	logic              core_clk = 0;
	logic              nrst = 0;
	tmc_pkg::tmc_req_t q = '0;
	logic [31:0]       rdata_r, d, e[$];
	logic              irq_r, p = 0;
	int                errors = 0, tests_run = 0;
	// Bench clock at 40 MHz.
	always #12.5 core_clk = ~core_clk;
	tmc_timer_match i_tmc_timer_match (.core_clk(core_clk), .nrst(nrst),
		.bus_req(q), .rdata_r(rdata_r), .irq_r(irq_r));
	// Read data stand one cycle only, so they are taken then.
	always @(posedge core_clk) begin
		if (p) c(e.pop_front(), rdata_r);
		p <= q.rd;
	end
	task automatic c(logic [31:0] x, y);
		tests_run++;
		if (x !== y) begin
			errors++;
			$display("mismatch %0t %h %h", $time, x, y);
		end
	endtask : c
	task automatic o(logic w, logic [7:0] a, logic [31:0] v);
		@(posedge core_clk) q <= '{a, v, w, !w};
	endtask : o
	task automatic rd(logic [7:0] a, logic [31:0] x);
		e.push_back(x);
		o(0, a, 0);
	endtask : rd
	task automatic i(int n, logic l);
		repeat (n) @(posedge core_clk) q <= '0;
		c(l, irq_r);
	endtask : i
	task automatic wt(int n);
		repeat (n) if (irq_r !== 1) @(posedge core_clk) q <= '0;
		c(1, irq_r);
		if (irq_r !== 1) conclude();
	endtask : wt
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	// Match with the interrupt enabled, then masked after a restart.
	initial begin
		d = 32'h20 + $urandom(16102) % 32'h40;
		repeat (10) @(posedge core_clk);
		nrst <= 1;
		rd(8'h24, 0);
		rd(8'h28, 0);
		rd(8'h2c, 0);
		rd(8'h20, 0);
		o(1, 8'h24, d);
		rd(8'h24, d);
		o(1, 8'h24, d);
		o(1, 8'h0c, 32'h10001);
		rd(8'h28, d);
		o(1, 8'h14, 32'h4);
		i(1, 0);
		wt(300);
		rd(8'h18, 32'h4);
		o(1, 8'h20, 32'h3);
		i(3, 1);
		o(1, 8'h20, 32'h4);
		i(3, 0);
		$display("test match done");
		o(1, 8'h14, 0);
		o(1, 8'h0c, 0);
		o(1, 8'h2c, d);
		rd(8'h2c, 0);
		d = 32'h8 + $urandom % 32'h10;
		o(1, 8'h24, d);
		o(1, 8'h0c, 32'h10001);
		i(64, 0);
		rd(8'h18, 32'h4);
		o(1, 8'h14, 32'h4);
		wt(4);
		o(1, 8'h14, 0);
		i(3, 0);
		$display("test mask done");
		conclude();
	end
endmodule : tb_top
